// [ebrc_pkg.sv]
package ebrc_pkg;
    localparam int unsigned addr_width   = 32;
    localparam int unsigned data_width   = 32;
    // Coherent block: 16 bytes, a whole number of 4-byte words
    localparam int unsigned granule_bits = 4;
    localparam int unsigned tag_width    = addr_width - granule_bits;

    localparam logic [tag_width-1:0] tag_reset = {tag_width{1'b0}};
    localparam logic [addr_width-1:0] addr_reset = {addr_width{1'b0}};
    localparam logic [data_width-1:0] data_reset = {data_width{1'b0}};

    typedef enum logic [2:0] {
        ebrc_idle,
        ebrc_wait_grant,
        ebrc_addr_phase,
        ebrc_wait_ack,
        ebrc_done
    } ebrc_state_type;
endpackage

// [ebrc_resv_if.sv]
`timescale 1ns/10ps
interface ebrc_resv_if;
    logic                            set_valid;
    logic [ebrc_pkg::tag_width-1:0]  set_tag;
    logic                            clear;
    logic                            snoop_store;
    logic [ebrc_pkg::tag_width-1:0]  snoop_tag;
    logic                            valid;
    logic [ebrc_pkg::tag_width-1:0]  tag;

    modport owner (
        input  set_valid,
        input  set_tag,
        input  clear,
        input  snoop_store,
        input  snoop_tag,
        output valid,
        output tag
    );
    modport user (
        output set_valid,
        output set_tag,
        output clear,
        output snoop_store,
        output snoop_tag,
        input  valid,
        input  tag
    );
endinterface

// [ebrc_resv_reg.sv]
`timescale 1ns/10ps
module ebrc_resv_reg (
    input  wire logic  clk_sys, // System clock
    input  wire logic  nrst,    // Sync reset, active low
    input  wire logic  ce,      // Clock enable
    ebrc_resv_if.owner rif      // Reservation control
);
    logic                           valid;
    logic [ebrc_pkg::tag_width-1:0] tag;
    logic                           snoop_hit;
    logic                           next_valid;

    assign snoop_hit  = rif.snoop_store && valid && (rif.snoop_tag == tag);
    // New reservation outranks a same-cycle clear or snoop: it is the later event
    assign next_valid = rif.set_valid ? 1'b1 :
                        (rif.clear || snoop_hit) ? 1'b0 :
                        valid;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            valid <= 1'b0;
            tag   <= ebrc_pkg::tag_reset;
        end else if (ce) begin
            valid <= next_valid;
            if (rif.set_valid) begin
                tag <= rif.set_tag;
            end
        end
    end

    assign rif.valid = valid;
    assign rif.tag   = tag;
endmodule

// [ebrc_ctrl.sv]
`timescale 1ns/10ps
// Notes on behaviour
// - At most one reservation is held for this processor.
// - Load-and-reserve sets a reservation, replacing any earlier one.
// - Store-conditional always clears the reservation, success or not.
// - Ordinary stores by this processor leave the reservation intact.
// - Another master's store to the reserved block cancels the reservation.
// - Lost reservation means the store-conditional never modifies memory.
// - Address compare uses coherent-block granularity, a multiple of words.
// - Cancel input sampled before the cycle; asserted means no cycle.
// - After address retry, cancel and grant are sampled again.
// - Cancel pin configured as port means reservation always valid.
// - Cancel input is active-low level; asserted means no external reservation.
// - Address retry, active low, tells the master to repeat its address phase.
// - Remote loss is reported only within the store-conditional cycle.
module ebrc_ctrl (
    input  wire logic                              clk_sys,              // System clock
    input  wire logic                              nrst,                 // Sync reset, active low
    input  wire logic                              ce,                   // Clock enable
    input  wire logic                              core_req,             // Core access request
    input  wire logic                              core_load_reserve,    // Load-and-reserve
    input  wire logic                              core_store_cond,      // Store-conditional
    input  wire logic                              core_store,           // Ordinary store
    input  wire logic [ebrc_pkg::addr_width-1:0]   core_addr,            // Access address
    input  wire logic [ebrc_pkg::data_width-1:0]   core_wdata,           // Store data
    input  wire logic                              snoop_store,          // Foreign store seen
    input  wire logic [ebrc_pkg::addr_width-1:0]   snoop_addr,           // Foreign store address
    input  wire logic                              cr_port_mode,         // Cancel pin used as port
    input  wire logic                              cancel_reservation_n, // Cancel pin
    input  wire logic                              address_retry_n,      // Retry pin
    input  wire logic                              bus_grant_n,          // Grant pin
    input  wire logic                              address_acknowledge_n,// Ack pin
    output logic                                   core_busy,            // Store-cond in progress
    output logic                                   core_done,            // Store-cond finished
    output logic                                   core_sc_success,      // Store-cond result
    output logic                                   resv_valid,           // Reservation held
    output logic                                   bus_request_n,        // Bus request out
    output logic                                   transfer_start_n,     // Address phase strobe
    output logic                                   bus_write,            // Write cycle marker
    output logic [ebrc_pkg::addr_width-1:0]        bus_addr,             // Bus address
    output logic [ebrc_pkg::data_width-1:0]        bus_wdata             // Bus write data
);
    logic [1:0] cr_sync;
    logic [1:0] retry_sync;
    logic [1:0] grant_sync;
    logic [1:0] ack_sync;
    logic       cr_n;
    logic       retry_n;
    logic       grant_n;
    logic       ack_n;

    ebrc_pkg::ebrc_state_type       state;
    ebrc_pkg::ebrc_state_type       next_state;
    logic [ebrc_pkg::addr_width-1:0] sc_addr;
    logic [ebrc_pkg::data_width-1:0] sc_data;
    logic                            sc_local_ok;

    ebrc_resv_if rif ();

    // Pins are asynchronous to clk_sys
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cr_sync    <= 2'h3;
            retry_sync <= 2'h3;
            grant_sync <= 2'h3;
            ack_sync   <= 2'h3;
        end else if (ce) begin
            cr_sync    <= {cr_sync[0], cancel_reservation_n};
            retry_sync <= {retry_sync[0], address_retry_n};
            grant_sync <= {grant_sync[0], bus_grant_n};
            ack_sync   <= {ack_sync[0], address_acknowledge_n};
        end
    end
    assign retry_n = retry_sync[1];
    assign grant_n = grant_sync[1];
    assign ack_n   = ack_sync[1];
    // Port mode forces the external reservation valid
    assign cr_n    = cr_port_mode ? 1'b1 : cr_sync[1];

    wire take_req   = ce && (state == ebrc_pkg::ebrc_idle) && core_req;
    wire take_sc    = take_req && core_store_cond;
    // Only the core's own reserved store-cond needs a bus cycle; a local
    // loss fails at once so memory is never touched
    wire sc_hit     = rif.valid &&
                      (core_addr[ebrc_pkg::addr_width-1:ebrc_pkg::granule_bits] == rif.tag);
    wire cancelled  = !cr_n;
    wire can_start  = !cancelled && !grant_n;
    wire ack_seen   = !ack_n;
    wire retry_seen = !retry_n;

    assign rif.set_valid   = take_req && core_load_reserve;
    assign rif.set_tag     = core_addr[ebrc_pkg::addr_width-1:ebrc_pkg::granule_bits];
    assign rif.clear       = take_sc;
    assign rif.snoop_store = snoop_store;
    assign rif.snoop_tag   = snoop_addr[ebrc_pkg::addr_width-1:ebrc_pkg::granule_bits];

    ebrc_resv_reg u_resv (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .ce      (ce),
        .rif     (rif)
    );

    always_comb begin
        next_state = state;
        case (state)
            ebrc_pkg::ebrc_idle: begin
                // Cancel already seen at take: fail without raising a request
                if (take_sc && sc_hit && !cancelled) begin
                    next_state = ebrc_pkg::ebrc_wait_grant;
                end else if (take_sc) begin
                    next_state = ebrc_pkg::ebrc_done;
                end
            end
            ebrc_pkg::ebrc_wait_grant: begin
                if (cancelled) begin
                    next_state = ebrc_pkg::ebrc_done;
                end else if (can_start) begin
                    next_state = ebrc_pkg::ebrc_addr_phase;
                end
            end
            ebrc_pkg::ebrc_addr_phase: begin
                next_state = ebrc_pkg::ebrc_wait_ack;
            end
            ebrc_pkg::ebrc_wait_ack: begin
                if (retry_seen) begin
                    next_state = ebrc_pkg::ebrc_wait_grant;
                end else if (ack_seen) begin
                    next_state = ebrc_pkg::ebrc_done;
                end
            end
            ebrc_pkg::ebrc_done: begin
                next_state = ebrc_pkg::ebrc_idle;
            end
            default: begin
                next_state = ebrc_pkg::ebrc_idle;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state       <= ebrc_pkg::ebrc_idle;
            sc_addr     <= ebrc_pkg::addr_reset;
            sc_data     <= ebrc_pkg::data_reset;
            sc_local_ok <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            if (take_sc) begin
                sc_addr     <= core_addr;
                sc_data     <= core_wdata;
                sc_local_ok <= sc_hit;
            end else if (state == ebrc_pkg::ebrc_wait_grant && cancelled) begin
                sc_local_ok <= 1'b0;
            end else if (state == ebrc_pkg::ebrc_wait_ack && retry_seen) begin
                sc_local_ok <= sc_local_ok;
            end
        end
    end

    wire enter_done = (next_state == ebrc_pkg::ebrc_done) && (state != ebrc_pkg::ebrc_done);
    wire drive_addr = (next_state == ebrc_pkg::ebrc_addr_phase);
    wire bus_owned  = (next_state == ebrc_pkg::ebrc_addr_phase) ||
                      (next_state == ebrc_pkg::ebrc_wait_ack);

    // Registered outputs; active-low bus pins idle high and bus_write idles low when no cycle runs
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            core_busy        <= 1'b0;
            core_done        <= 1'b0;
            core_sc_success  <= 1'b0;
            resv_valid       <= 1'b0;
            bus_request_n    <= 1'b1;
            transfer_start_n <= 1'b1;
            bus_write        <= 1'b0;
            bus_addr         <= ebrc_pkg::addr_reset;
            bus_wdata        <= ebrc_pkg::data_reset;
        end else if (ce) begin
            core_busy        <= (next_state != ebrc_pkg::ebrc_idle) &&
                                (next_state != ebrc_pkg::ebrc_done);
            core_done        <= enter_done;
            // Success only when the acknowledge ends a bus cycle
            core_sc_success  <= enter_done && (state == ebrc_pkg::ebrc_wait_ack) &&
                                sc_local_ok;
            resv_valid       <= rif.valid;
            bus_request_n    <= !((next_state == ebrc_pkg::ebrc_wait_grant) || bus_owned);
            transfer_start_n <= !drive_addr;
            bus_write        <= bus_owned;
            if (drive_addr) begin
                bus_addr  <= sc_addr;
                bus_wdata <= sc_data;
            end
        end
    end
endmodule

// [ebrc_far_model.sv]
`timescale 1ns/10ps
module ebrc_far_model (
    input  wire logic       clk_sys,              // System clock
    input  wire logic       nrst,                 // Sync reset, active low
    input  wire logic       lost,                 // Local reservation lost
    input  wire logic       remote_lost,          // Non-local reservation lost
    input  wire logic [1:0] retries,              // Retries before ack
    input  wire logic       bus_request_n,        // Request from device
    input  wire logic       transfer_start_n,     // Address strobe from device
    output logic            cancel_reservation_n, // Cancel level to device
    output logic            address_retry_n,      // Retry to device
    output logic            bus_grant_n,          // Grant to device
    output logic            address_acknowledge_n // Ack to device
);
    logic [1:0] used;
    // Level only, no pulse: loss shows up when the device looks for it
    assign cancel_reservation_n = !lost;
    always_ff @(posedge clk_sys) begin
        address_retry_n       <= 1'b1;
        address_acknowledge_n <= 1'b1;
        bus_grant_n           <= bus_request_n | !nrst;
        if (!nrst || bus_request_n) begin
            used <= 2'h0;
        end else if (!transfer_start_n) begin
            if (remote_lost || used != retries) begin
                address_retry_n <= 1'b0;
                used            <= used + 2'h1;
            end else begin
                address_acknowledge_n <= 1'b0;
            end
        end
    end
endmodule

// [ebrc_monitor.sv]
`timescale 1ns/10ps
module ebrc_monitor (
    input wire logic clk_sys,               // System clock
    input wire logic nrst,                  // Sync reset
    input wire logic core_req,              // Core request
    input wire logic core_store_cond,       // Store-cond
    input wire logic cr_port_mode,          // Cancel pin as port
    input wire logic cancel_reservation_n,  // Cancel pin
    input wire logic address_retry_n,       // Retry pin
    input wire logic address_acknowledge_n, // Ack pin
    input wire logic core_busy,             // Busy
    input wire logic core_done,             // Done pulse
    input wire logic core_sc_success,       // Result
    input wire logic resv_valid,            // Reservation held
    input wire logic bus_request_n,         // Bus request
    input wire logic transfer_start_n,      // Address strobe
    input wire logic bus_write              // Write marker
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    ts_needs_bus_a: assert property (
        !transfer_start_n |-> !bus_request_n && bus_write)
        else $error("address strobe without bus ownership");
    ts_pulse_a: assert property ($fell(transfer_start_n) |=> transfer_start_n)
        else $error("address strobe longer than one cycle");
    cancel_blocks_a: assert property (
        (!cancel_reservation_n && !cr_port_mode)[*5] |-> transfer_start_n)
        else $error("cycle started while cancelled");
    done_pulse_a: assert property (
        core_done |-> !core_busy && bus_request_n ##1 !core_done)
        else $error("done not a clean pulse");
    // Done rises at the edge after the take; the bus stays quiet in that cycle and the next
    miss_quiet_a: assert property (
        core_req && core_store_cond && !core_busy && !core_done
        && !resv_valid && !$past(resv_valid) && !$past(core_req)
        |=> core_done && !core_sc_success && bus_request_n && transfer_start_n
        ##1 bus_request_n && transfer_start_n)
        else $error("local miss not failed quietly");
    req_hold_a: assert property (!bus_request_n |=> !bus_request_n || core_done)
        else $error("bus request dropped early");
    retry_rerun_a: assert property (
        $fell(address_retry_n) |-> ##[2:14] (!transfer_start_n || core_done))
        else $error("retry not followed up");
    ack_success_a: assert property (
        $fell(address_acknowledge_n) |-> ##[1:6] core_done && core_sc_success)
        else $error("ack not reported as success");
    cover property (core_done && core_sc_success);
    cover property (core_done && !core_sc_success);
    cover property ($fell(address_retry_n));
endmodule

// [testbench.sv]
`timescale 1ns/10ps
module testbench;
    logic        clk_sys, nrst, ce, core_req, core_load_reserve, core_store_cond, core_store;
    logic        snoop_store, cr_port_mode, lost, remote_lost, ok;
    logic        core_busy, core_done, core_sc_success;
    logic        cancel_reservation_n, address_retry_n, bus_grant_n, address_acknowledge_n;
    logic        resv_valid, bus_request_n, transfer_start_n, bus_write;
    logic [31:0] core_addr, core_wdata, snoop_addr, bus_addr, bus_wdata, seen_addr, seen_data;
    logic [1:0]  retries;
    int          miscompares, checks_done, n_ts, n_req;
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    ebrc_ctrl dut_u (.clk_sys, .nrst, .ce, .core_req, .core_load_reserve, .core_store_cond,
        .core_store, .core_addr, .core_wdata, .snoop_store, .snoop_addr, .cr_port_mode,
        .cancel_reservation_n, .address_retry_n, .bus_grant_n, .address_acknowledge_n,
        .core_busy, .core_done, .core_sc_success, .resv_valid, .bus_request_n,
        .transfer_start_n, .bus_write, .bus_addr, .bus_wdata);
    ebrc_far_model far_u (.clk_sys, .nrst, .lost, .remote_lost, .retries, .bus_request_n,
        .transfer_start_n, .cancel_reservation_n, .address_retry_n, .bus_grant_n,
        .address_acknowledge_n);
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic conclude;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Kind is {load-reserve, store-cond, store}; drop kills the reservation mid-cycle
    task automatic access(input logic [2:0] kind, input logic [31:0] a, input logic drop);
        int i;
        @(negedge clk_sys);
        {core_load_reserve, core_store_cond, core_store} = kind;
        core_req = 1'b1;
        core_addr = a;
        core_wdata = a ^ 32'h5a5a0000;
        @(negedge clk_sys);
        core_req = 1'b0;
        n_ts = 0;
        n_req = 0;
        for (i = 0; i < 60 && kind == 3'h2; i++) begin
            if (bus_request_n === 1'b0) n_req++;
            if (transfer_start_n === 1'b0) begin
                n_ts++;
                seen_addr = bus_addr;
                seen_data = bus_wdata;
                lost = lost | drop;
                remote_lost = remote_lost | drop;
            end
            if (core_done === 1'b1) break;
            @(negedge clk_sys);
        end
        ok = core_sc_success;
        if (i == 60) begin
            miscompares++;
            conclude();
        end
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic sc(input logic [31:0] a, input logic drop, input logic exp_ok, input int exp_ts);
        access(3'h2, a, drop);
        chk("sc result", {31'h0, exp_ok}, {31'h0, ok});
        chk("strobe count", exp_ts, n_ts);
        if (exp_ts > 0) chk("bus addr", a, seen_addr);
        if (exp_ts > 0) chk("bus data", a ^ 32'h5a5a0000, seen_data);
        if (exp_ts == 0) chk("bus request", 32'h0, n_req);
    endtask
    task automatic snoop(input logic [31:0] a);
        @(negedge clk_sys);
        snoop_store = 1'b1;
        snoop_addr = a;
        @(negedge clk_sys);
        snoop_store = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
    initial begin
        {nrst, core_req, core_load_reserve, core_store_cond, core_store, snoop_store} = 6'h0;
        {cr_port_mode, lost, remote_lost, retries, core_addr, core_wdata, snoop_addr} = 'h0;
        ce = 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        nrst = 1'b1;
        chk("resv reset", 32'h0, {31'h0, resv_valid});
        // Frozen block must ignore a load-reserve
        ce = 1'b0;
        access(3'h4, 32'h7000, 1'b0);
        ce = 1'b1;
        chk("resv frozen", 32'h0, {31'h0, resv_valid});
        sc(32'h1000, 1'b0, 1'b0, 0);
        access(3'h4, 32'h1000, 1'b0);
        chk("resv after lr", 32'h1, {31'h0, resv_valid});
        access(3'h1, 32'h1000, 1'b0);
        chk("resv after store", 32'h1, {31'h0, resv_valid});
        snoop(32'h1010);
        chk("resv other block", 32'h1, {31'h0, resv_valid});
        sc(32'h100c, 1'b0, 1'b1, 1);
        chk("resv after sc", 32'h0, {31'h0, resv_valid});
        sc(32'h100c, 1'b0, 1'b0, 0);
        access(3'h4, 32'h1000, 1'b0);
        access(3'h4, 32'h2000, 1'b0);
        sc(32'h1000, 1'b0, 1'b0, 0);
        access(3'h4, 32'h3000, 1'b0);
        snoop(32'h300c);
        chk("resv after snoop", 32'h0, {31'h0, resv_valid});
        sc(32'h3000, 1'b0, 1'b0, 0);
        lost = 1'b1;
        access(3'h4, 32'h4000, 1'b0);
        sc(32'h4000, 1'b0, 1'b0, 0);
        // Pin held low as a port; no non-local loss, so the cycle completes
        cr_port_mode = 1'b1;
        access(3'h4, 32'h4000, 1'b0);
        sc(32'h4004, 1'b0, 1'b1, 1);
        {cr_port_mode, lost, retries} = 4'h1;
        access(3'h4, 32'h5000, 1'b0);
        sc(32'h5008, 1'b0, 1'b1, 2);
        retries = 2'h0;
        access(3'h4, 32'h6000, 1'b0);
        sc(32'h6000, 1'b1, 1'b0, 1);
        conclude();
    end
endmodule
bind ebrc_ctrl ebrc_monitor mon_u (.clk_sys, .nrst, .core_req, .core_store_cond, .cr_port_mode,
    .cancel_reservation_n, .address_retry_n, .address_acknowledge_n, .core_busy, .core_done,
    .core_sc_success, .resv_valid, .bus_request_n, .transfer_start_n, .bus_write);
